//--- hdl/ses_pkg.sv
// Shared constants and types of the status event summary block
package ses_pkg;

  localparam int N_OUT  = 3;
  localparam int QUESTIONABLE_SUMMARY_BIT_W = 16;
  localparam int INST_W = 4;
  localparam int OUTPUT_SUMMARY_BIT_W = 2;
  localparam int STD_W  = 8;
  localparam int STB_W  = 8;
  localparam int ERR_W  = 4;

  // Field positions
  localparam int QUESTIONABLE_SUMMARY_BIT_FAN_BIT    = 4;
  localparam int QUESTIONABLE_SUMMARY_BIT_OUTSUM_BIT = 13;
  localparam int INST_OUT_BASE   = 1;
  localparam int OUTPUT_SUMMARY_BIT_VOLT_BIT   = 0;
  localparam int OUTPUT_SUMMARY_BIT_CURR_BIT   = 1;
  localparam int COND_CC_BIT     = 0;
  localparam int COND_CV_BIT     = 1;
  localparam int STD_OPC_BIT     = 0;
  localparam int STD_QYE_BIT     = 2;
  localparam int STD_DDE_BIT     = 3;
  localparam int STD_EXE_BIT     = 4;
  localparam int STD_CME_BIT     = 5;
  localparam int STD_PON_BIT     = 7;
  localparam int STB_QUESTIONABLE_SUMMARY_BIT_BIT    = 3;
  localparam int STB_MAV_BIT     = 4;
  localparam int STB_ESB_BIT     = 5;
  localparam int STB_RQS_BIT     = 6;

  // Implemented bits and reset values
  localparam logic [QUESTIONABLE_SUMMARY_BIT_W-1:0] QUESTIONABLE_SUMMARY_BIT_VALID  = 16'h2010;
  localparam logic [QUESTIONABLE_SUMMARY_BIT_W-1:0] QUESTIONABLE_SUMMARY_BIT_RST    = 16'h0000;
  localparam logic [INST_W-1:0] INST_VALID  = 4'hE;
  localparam logic [INST_W-1:0] INST_RST    = 4'h0;
  localparam logic [OUTPUT_SUMMARY_BIT_W-1:0] OUTPUT_SUMMARY_BIT_VALID  = 2'h3;
  localparam logic [OUTPUT_SUMMARY_BIT_W-1:0] OUTPUT_SUMMARY_BIT_RST    = 2'h0;
  localparam logic [STD_W-1:0]  STD_VALID   = 8'hBD;
  localparam logic [STD_W-1:0]  STD_RST     = 8'h80;
  localparam logic [STD_W-1:0]  STD_ERR_MSK = 8'h3C;
  localparam logic [STB_W-1:0]  SRE_VALID   = 8'h38;
  localparam logic [STB_W-1:0]  SRE_RST     = 8'h00;
  localparam logic              PSC_RST     = 1'b1;

  typedef enum logic [4:0] {
    OP_RD_QUESTIONABLE_SUMMARY_BIT_EV, OP_RD_QUESTIONABLE_SUMMARY_BIT_EN, OP_WR_QUESTIONABLE_SUMMARY_BIT_EN,
    OP_RD_INST_EV, OP_RD_INST_EN, OP_WR_INST_EN,
    OP_RD_OUTPUT_SUMMARY_BIT_EV, OP_RD_OUTPUT_SUMMARY_BIT_EN, OP_WR_OUTPUT_SUMMARY_BIT_EN, OP_RD_OUTPUT_SUMMARY_BIT_COND,
    OP_RD_STD_EV, OP_RD_STD_EN, OP_WR_STD_EN,
    OP_RD_STB, OP_SERIAL_POLL, OP_RD_SRE, OP_WR_SRE,
    OP_CLS, OP_WR_PSC, OP_RD_PSC
  } ses_op_t;

endpackage

//--- hdl/ses_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module ses_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout_q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit moves only when stages two and three agree
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dout_q <= '0;
    end else begin
      dout_q <= (s2_q & s3_q) | (dout_q & (s2_q ^ s3_q));
    end
  end
endmodule
`default_nettype wire

//--- hdl/ses_evreg.sv
// Sticky event register with enable mask and summary
`timescale 1ns/1ps
`default_nettype none
module ses_evreg #(
  parameter int           W     = 8,
  parameter logic [W-1:0] RST   = '0,
  parameter logic [W-1:0] VALID = '1
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] set,
  input  wire logic         clr,
  input  wire logic         en_we,
  input  wire logic [W-1:0] en_wd,
  input  wire logic         en_clr,
  output logic      [W-1:0] ev_q,
  output logic      [W-1:0] en_q,
  output logic              sum
);
  // Set wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ev_q <= RST;
    end else begin
      ev_q <= ((clr ? '0 : ev_q) | set) & VALID;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      en_q <= '0;
    end else if (en_we) begin
      en_q <= en_wd & VALID;
    end else if (en_clr) begin
      en_q <= '0;
    end
  end

  assign sum = |(ev_q & en_q);
endmodule
`default_nettype wire

//--- hdl/ses_top.sv
// Status event summary: event registers, masks and status byte
// How it works
// - Fan fault sets questionable bit 4.
// - Enabled output events latch questionable bit 13.
// - Outputs map to bits 1, 2, 3.
// - Per-output bit0 voltage, bit1 current unregulated.
// - Condition: bit1 CV, bit0 CC.
// - Output mask gates output summary bit.
// - Per-output mask gates its output bit.
// - Clear-status or read clears questionable events.
// - Questionable mask changes only by write.
// - Status bit 5 is enabled standard events.
// - Standard error bits push error queue entry.
// - Operation complete sets bit 0; 1,6 zero.
// - Query errors set weight 4.
// - Device, execution, syntax errors set 8,16,32.
// - Power cycle sets bit 7 until cleared.
// - Clear-status or read clears standard events.
// - Standard mask cleared by write or power-on.
// - Status bit 4 follows pending output data.
// - Status byte bits 3-5 follow sources, unlatched; bit 6 is latched.
// - Bit 3 questionable summary; 0-2,7 zero.
// - Standard read clears only status bit 5.
// - Request mask cleared by write or power-on.
// - Event bits stay set until cleared.
// - Enabled summary raises a service request.
// - Serial poll clears only request bit.
`timescale 1ns/1ps
`default_nettype none
module ses_top
  import ses_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic              cmd_valid,
  input  wire ses_op_t           cmd_op,
  input  wire logic [1:0]        cmd_idx,
  input  wire logic [QUESTIONABLE_SUMMARY_BIT_W-1:0] cmd_wdata,
  output logic                   rsp_valid,
  output logic      [QUESTIONABLE_SUMMARY_BIT_W-1:0] rsp_data,
  input  wire logic              fan_fault,
  input  wire logic [N_OUT-1:0]  constant_voltage_state,
  input  wire logic [N_OUT-1:0]  constant_current_state,
  input  wire logic              power_cycle,
  input  wire logic              opc_done,
  input  wire logic              obuf_read_empty,
  input  wire logic              cmd_before_read,
  input  wire logic              bufs_full,
  input  wire logic              selftest_err,
  input  wire logic              exec_err,
  input  wire logic              syntax_err,
  input  wire logic              obuf_avail,
  output logic                   err_push,
  output logic      [ERR_W-1:0]  err_kind,
  output logic                   service_request
);

  function automatic logic hit(input logic v, input ses_op_t o, input ses_op_t want);
    hit = v && (o == want);
  endfunction

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic             fan_s;
  logic [N_OUT-1:0] cv_s;
  logic [N_OUT-1:0] cc_s;

  ses_sync #(.W(2 * N_OUT + 1)) u_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .din    ({fan_fault, constant_voltage_state, constant_current_state}),
    .dout_q ({fan_s, cv_s, cc_s})
  );

  wire cls         = hit(cmd_valid, cmd_op, OP_CLS);
  wire rd_questionable_summary_bit_ev  = hit(cmd_valid, cmd_op, OP_RD_QUESTIONABLE_SUMMARY_BIT_EV);
  wire rd_inst_ev  = hit(cmd_valid, cmd_op, OP_RD_INST_EV);
  wire rd_output_summary_bit_ev  = hit(cmd_valid, cmd_op, OP_RD_OUTPUT_SUMMARY_BIT_EV);
  wire rd_std_ev   = hit(cmd_valid, cmd_op, OP_RD_STD_EV);
  wire serial_poll = hit(cmd_valid, cmd_op, OP_SERIAL_POLL);

  logic [OUTPUT_SUMMARY_BIT_W-1:0] output_summary_bit_ev  [N_OUT];
  logic [OUTPUT_SUMMARY_BIT_W-1:0] output_summary_bit_en  [N_OUT];
  logic [OUTPUT_SUMMARY_BIT_W-1:0] output_summary_bit_cnd [N_OUT];
  logic [N_OUT-1:0]  output_summary_bit_sum;

  genvar gi;
  generate
    for (gi = 0; gi < N_OUT; gi++) begin : g_out
      logic [OUTPUT_SUMMARY_BIT_W-1:0] cond_prev_q;
      logic [OUTPUT_SUMMARY_BIT_W-1:0] set;

      assign output_summary_bit_cnd[gi] = {cv_s[gi], cc_s[gi]};

      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          cond_prev_q <= '0;
        end else begin
          cond_prev_q <= output_summary_bit_cnd[gi];
        end
      end

      // Leaving the regulated mode counts as soon as the other mode's bit rises after one cycle in that mode alone
      always_comb begin
        set                = '0;
        set[OUTPUT_SUMMARY_BIT_VOLT_BIT] = cond_prev_q[COND_CV_BIT] && !cond_prev_q[COND_CC_BIT]
                             && output_summary_bit_cnd[gi][COND_CC_BIT];
        set[OUTPUT_SUMMARY_BIT_CURR_BIT] = cond_prev_q[COND_CC_BIT] && !cond_prev_q[COND_CV_BIT]
                             && output_summary_bit_cnd[gi][COND_CV_BIT];
      end

      ses_evreg #(.W(OUTPUT_SUMMARY_BIT_W), .RST(OUTPUT_SUMMARY_BIT_RST), .VALID(OUTPUT_SUMMARY_BIT_VALID)) u_output_summary_bit (
        .mclk   (mclk),
        .arst_n (arst_n),
        .set    (set),
        .clr    (cls || (rd_output_summary_bit_ev && cmd_idx == 2'(gi))),
        .en_we  (hit(cmd_valid, cmd_op, OP_WR_OUTPUT_SUMMARY_BIT_EN) && cmd_idx == 2'(gi)),
        .en_wd  (cmd_wdata[OUTPUT_SUMMARY_BIT_W-1:0]),
        .en_clr (1'b0),
        .ev_q   (output_summary_bit_ev[gi]),
        .en_q   (output_summary_bit_en[gi]),
        .sum    (output_summary_bit_sum[gi])
      );
    end
  endgenerate

  logic [INST_W-1:0] inst_set;
  logic [INST_W-1:0] inst_ev;
  logic [INST_W-1:0] inst_en;
  logic              output_summary_bit;

  always_comb begin
    inst_set = '0;
    inst_set[INST_OUT_BASE +: N_OUT] = output_summary_bit_sum;
  end

  ses_evreg #(.W(INST_W), .RST(INST_RST), .VALID(INST_VALID)) u_inst (
    .mclk   (mclk),
    .arst_n (arst_n),
    .set    (inst_set),
    .clr    (cls || rd_inst_ev),
    .en_we  (hit(cmd_valid, cmd_op, OP_WR_INST_EN)),
    .en_wd  (cmd_wdata[INST_W-1:0]),
    .en_clr (1'b0),
    .ev_q   (inst_ev),
    .en_q   (inst_en),
    .sum    (output_summary_bit)
  );
  property p_inst_map;
    (output_summary_bit_sum != '0) |=> ((inst_ev[INST_OUT_BASE +: N_OUT] & $past(output_summary_bit_sum)) == $past(output_summary_bit_sum));
  endproperty
  a_inst_map: assert property (p_inst_map) else $error("output not on its bit");

  logic [QUESTIONABLE_SUMMARY_BIT_W-1:0] questionable_summary_bit_set;
  logic [QUESTIONABLE_SUMMARY_BIT_W-1:0] questionable_summary_bit_ev;
  logic [QUESTIONABLE_SUMMARY_BIT_W-1:0] questionable_summary_bit_en;
  logic              questionable_summary_bit;

  always_comb begin
    questionable_summary_bit_set                  = '0;
    questionable_summary_bit_set[QUESTIONABLE_SUMMARY_BIT_FAN_BIT]    = fan_s;
    questionable_summary_bit_set[QUESTIONABLE_SUMMARY_BIT_OUTSUM_BIT] = output_summary_bit;
  end

  // Mask untouched by clear-status or reads
  ses_evreg #(.W(QUESTIONABLE_SUMMARY_BIT_W), .RST(QUESTIONABLE_SUMMARY_BIT_RST), .VALID(QUESTIONABLE_SUMMARY_BIT_VALID)) u_questionable_summary_bit (
    .mclk   (mclk),
    .arst_n (arst_n),
    .set    (questionable_summary_bit_set),
    .clr    (cls || rd_questionable_summary_bit_ev),
    .en_we  (hit(cmd_valid, cmd_op, OP_WR_QUESTIONABLE_SUMMARY_BIT_EN)),
    .en_wd  (cmd_wdata),
    .en_clr (1'b0),
    .ev_q   (questionable_summary_bit_ev),
    .en_q   (questionable_summary_bit_en),
    .sum    (questionable_summary_bit)
  );
  property p_fan;
    fan_s |=> questionable_summary_bit_ev[QUESTIONABLE_SUMMARY_BIT_FAN_BIT];
  endproperty
  a_fan: assert property (p_fan) else $error("fan bit not set");
  property p_outsum;
    output_summary_bit |=> questionable_summary_bit_ev[QUESTIONABLE_SUMMARY_BIT_OUTSUM_BIT];
  endproperty
  a_outsum: assert property (p_outsum) else $error("output summary not latched");
  property p_questionable_summary_bit_clr;
    (rd_questionable_summary_bit_ev && !fan_s && !output_summary_bit) |=> (questionable_summary_bit_ev == '0);
  endproperty
  a_questionable_summary_bit_clr: assert property (p_questionable_summary_bit_clr) else $error("questionable not cleared");
  property p_questionable_summary_bit_en_keep;
    (cls || rd_questionable_summary_bit_ev || hit(cmd_valid, cmd_op, OP_RD_QUESTIONABLE_SUMMARY_BIT_EN)) |=> (questionable_summary_bit_en == $past(questionable_summary_bit_en));
  endproperty
  a_questionable_summary_bit_en_keep: assert property (p_questionable_summary_bit_en_keep) else $error("mask changed");

  logic             psc_q;
  logic             pwr_clr;
  logic [STD_W-1:0] std_set;
  logic [STD_W-1:0] std_ev;
  logic [STD_W-1:0] std_en;
  logic             esb;
  logic             wr_std_en;

  assign pwr_clr   = power_cycle && psc_q;
  assign wr_std_en = hit(cmd_valid, cmd_op, OP_WR_STD_EN);

  always_comb begin
    std_set              = '0;
    std_set[STD_OPC_BIT] = opc_done;
    std_set[STD_QYE_BIT] = obuf_read_empty || cmd_before_read || bufs_full;
    std_set[STD_DDE_BIT] = selftest_err;
    std_set[STD_EXE_BIT] = exec_err;
    std_set[STD_CME_BIT] = syntax_err;
    std_set[STD_PON_BIT] = power_cycle;
  end

  // Bits 1 and 6 are outside the valid mask
  ses_evreg #(.W(STD_W), .RST(STD_RST), .VALID(STD_VALID)) u_std (
    .mclk   (mclk),
    .arst_n (arst_n),
    .set    (std_set),
    .clr    (cls || rd_std_ev),
    .en_we  (wr_std_en),
    .en_wd  (cmd_wdata[STD_W-1:0]),
    .en_clr (pwr_clr),
    .ev_q   (std_ev),
    .en_q   (std_en),
    .sum    (esb)
  );

  // Queue storage lives elsewhere; this only announces entries
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      err_push <= 1'b0;
      err_kind <= '0;
    end else begin
      err_push <= |(std_set & STD_ERR_MSK);
      err_kind <= std_set[STD_CME_BIT:STD_QYE_BIT];
    end
  end
  property p_err_push;
    (|(std_set & STD_ERR_MSK)) |=> err_push;
  endproperty
  a_err_push: assert property (p_err_push) else $error("no error push");

  // Power-on-clear setting survives power cycles
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      psc_q <= PSC_RST;
    end else if (hit(cmd_valid, cmd_op, OP_WR_PSC)) begin
      psc_q <= cmd_wdata[0];
    end
  end
  property p_pon;
    power_cycle |=> std_ev[STD_PON_BIT] && (std_en == '0 || !$past(psc_q) || $past(wr_std_en));
  endproperty
  a_pon: assert property (p_pon) else $error("power-on handling wrong");

  logic [STB_W-1:0] sre_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sre_q <= SRE_RST;
    end else if (hit(cmd_valid, cmd_op, OP_WR_SRE)) begin
      sre_q <= cmd_wdata[STB_W-1:0] & SRE_VALID;
    end else if (pwr_clr) begin
      sre_q <= '0;
    end
  end
  property p_sre_pwr;
    (pwr_clr && !hit(cmd_valid, cmd_op, OP_WR_SRE)) |=> (sre_q == '0);
  endproperty
  a_sre_pwr: assert property (p_sre_pwr) else $error("request mask kept");

  // Summary bits are wires, so clearing a source clears them
  logic [STB_W-1:0] stb;
  logic             rqs_q;
  logic             srq_cond;
  logic             srq_prev_q;

  always_comb begin
    stb               = '0;
    stb[STB_QUESTIONABLE_SUMMARY_BIT_BIT] = questionable_summary_bit;
    stb[STB_MAV_BIT]  = obuf_avail;
    stb[STB_ESB_BIT]  = esb;
    stb[STB_RQS_BIT]  = rqs_q;
  end
  property p_stb_zero;
    (stb[2:0] == 3'h0) && !stb[7];
  endproperty
  a_stb_zero: assert property (p_stb_zero) else $error("reserved status bit set");

  assign srq_cond = |(stb & sre_q & SRE_VALID);
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      srq_prev_q <= 1'b0;
    end else begin
      srq_prev_q <= srq_cond;
    end
  end

  // A new request beats a poll in the same cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rqs_q <= 1'b0;
    end else if (srq_cond && !srq_prev_q) begin
      rqs_q <= 1'b1;
    end else if (serial_poll || !srq_cond) begin
      rqs_q <= 1'b0;
    end
  end
  property p_poll;
    (serial_poll && srq_prev_q) |=> !rqs_q;
  endproperty
  a_poll: assert property (p_poll) else $error("poll left request set");

  assign service_request = rqs_q;
  logic [QUESTIONABLE_SUMMARY_BIT_W-1:0] rd_mux;
  logic [OUTPUT_SUMMARY_BIT_W-1:0] sel_ev;
  logic [OUTPUT_SUMMARY_BIT_W-1:0] sel_en;
  logic [OUTPUT_SUMMARY_BIT_W-1:0] sel_cnd;

  // Index 3 selects no output and reads zero
  always_comb begin
    sel_ev  = '0;
    sel_en  = '0;
    sel_cnd = '0;
    for (int i = 0; i < N_OUT; i++) begin
      if (cmd_idx == 2'(i)) begin
        sel_ev  = output_summary_bit_ev[i];
        sel_en  = output_summary_bit_en[i];
        sel_cnd = output_summary_bit_cnd[i];
      end
    end
  end

  always_comb begin
    rd_mux = '0;
    unique case (cmd_op)
      OP_RD_QUESTIONABLE_SUMMARY_BIT_EV:   rd_mux = questionable_summary_bit_ev;
      OP_RD_QUESTIONABLE_SUMMARY_BIT_EN:   rd_mux = questionable_summary_bit_en;
      OP_RD_INST_EV:   rd_mux = {12'h000, inst_ev};
      OP_RD_INST_EN:   rd_mux = {12'h000, inst_en};
      OP_RD_OUTPUT_SUMMARY_BIT_EV:   rd_mux = {14'h0000, sel_ev};
      OP_RD_OUTPUT_SUMMARY_BIT_EN:   rd_mux = {14'h0000, sel_en};
      OP_RD_OUTPUT_SUMMARY_BIT_COND: rd_mux = {14'h0000, sel_cnd};
      OP_RD_STD_EV:    rd_mux = {8'h00, std_ev};
      OP_RD_STD_EN:    rd_mux = {8'h00, std_en};
      OP_RD_STB,
      OP_SERIAL_POLL:  rd_mux = {8'h00, stb};
      OP_RD_SRE:       rd_mux = {8'h00, sre_q};
      OP_RD_PSC:       rd_mux = {15'h0000, psc_q};
      default:         rd_mux = '0;
    endcase
  end

  // Every command is answered once, writes with zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end else begin
      rsp_valid <= cmd_valid;
      rsp_data  <= cmd_valid ? rd_mux : '0;
    end
  end
endmodule
`default_nettype wire

//--- testbench/ses_host.sv
// Host bus controller model issuing status commands
`timescale 1ns/1ps
`default_nettype none
module ses_host
  import ses_pkg::*;
(
  input  wire logic              mclk,
  output logic                   cmd_valid,
  output var ses_op_t            cmd_op,
  output logic      [1:0]        cmd_idx,
  output logic      [QUESTIONABLE_SUMMARY_BIT_W-1:0] cmd_wdata,
  input  wire logic              rsp_valid,
  input  wire logic [QUESTIONABLE_SUMMARY_BIT_W-1:0] rsp_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_op    = OP_RD_STB;
    cmd_idx   = 2'h0;
    cmd_wdata = 16'h0000;
  end

  // One command per call; answer is due exactly one cycle after the strobe
  task automatic xfer(input ses_op_t op, input logic [1:0] idx,
                      input logic [QUESTIONABLE_SUMMARY_BIT_W-1:0] wd, output logic [QUESTIONABLE_SUMMARY_BIT_W-1:0] rd);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_op    = op;
    cmd_idx   = idx;
    cmd_wdata = wd;
    @(negedge mclk);
    cmd_valid = 1'b0;
    // Idle bus shows inverted data so a stale value is never mistaken
    cmd_wdata = ~wd;
    cmd_idx   = ~idx;
    if (rsp_valid === 1'b1) begin
      rd = rsp_data;
    end else begin
      rd = 'x;
    end
  endtask
endmodule
`default_nettype wire

//--- testbench/ses_top_test.sv
// Self-checking bench for the status event summary block
`timescale 1ns/1ps
`default_nettype none
module ses_top_test
  import ses_pkg::*;
;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic        cmd_valid;
  ses_op_t     cmd_op;
  logic [1:0]  cmd_idx;
  logic [15:0] cmd_wdata;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  logic        fan_fault = 1'b0;
  logic [2:0]  cv = 3'h0;
  logic [2:0]  cc = 3'h0;
  logic        power_cycle = 1'b0;
  logic [6:0]  ev = 7'h00;
  logic        obuf_avail = 1'b0;
  logic        err_push;
  logic [3:0]  err_kind;
  logic        service_request;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [15:0] wgt [7] = '{16'h0001, 16'h0004, 16'h0004, 16'h0004, 16'h0008, 16'h0010, 16'h0020};
  logic [3:0]  kind [7] = '{4'h0, 4'h1, 4'h1, 4'h1, 4'h2, 4'h4, 4'h8};

  always #2.5 mclk = ~mclk;

  ses_top i_ses_top (
    .mclk                   (mclk),
    .arst_n                 (arst_n),
    .cmd_valid              (cmd_valid),
    .cmd_op                 (cmd_op),
    .cmd_idx                (cmd_idx),
    .cmd_wdata              (cmd_wdata),
    .rsp_valid              (rsp_valid),
    .rsp_data               (rsp_data),
    .fan_fault              (fan_fault),
    .constant_voltage_state (cv),
    .constant_current_state (cc),
    .power_cycle            (power_cycle),
    .opc_done               (ev[0]),
    .obuf_read_empty        (ev[1]),
    .cmd_before_read        (ev[2]),
    .bufs_full              (ev[3]),
    .selftest_err           (ev[4]),
    .exec_err               (ev[5]),
    .syntax_err             (ev[6]),
    .obuf_avail             (obuf_avail),
    .err_push               (err_push),
    .err_kind               (err_kind),
    .service_request        (service_request)
  );

  ses_host i_ses_host (
    .mclk      (mclk),
    .cmd_valid (cmd_valid),
    .cmd_op    (cmd_op),
    .cmd_idx   (cmd_idx),
    .cmd_wdata (cmd_wdata),
    .rsp_valid (rsp_valid),
    .rsp_data  (rsp_data)
  );

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdc(input ses_op_t op, input logic [1:0] idx, input logic [15:0] exp);
    logic [15:0] d;
    i_ses_host.xfer(op, idx, 16'h0000, d);
    chk(d, exp);
  endtask

  task automatic wr(input ses_op_t op, input logic [1:0] idx, input logic [15:0] wd);
    logic [15:0] d;
    i_ses_host.xfer(op, idx, wd, d);
    chk(d, 16'h0000);
  endtask

  task automatic settle();
    repeat (8) @(negedge mclk);
  endtask

  always @(posedge mclk) begin
    cycles++;
    // Generous ceiling; the sequence needs well under a thousand cycles
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  initial begin
    repeat (8) @(negedge mclk);
    arst_n = 1'b1;
    rdc(OP_RD_STD_EV, 2'h0, 16'h0080);
    rdc(OP_RD_STD_EV, 2'h0, 16'h0000);
    rdc(OP_RD_STB, 2'h0, 16'h0000);
    // Regulation chain through all three outputs
    wr(OP_WR_INST_EN, 2'h0, 16'h000E);
    rdc(OP_RD_INST_EN, 2'h0, 16'h000E);
    for (int n = 0; n < 3; n++) begin
      wr(OP_WR_OUTPUT_SUMMARY_BIT_EN, n[1:0], 16'h0003);
      rdc(OP_RD_OUTPUT_SUMMARY_BIT_EN, n[1:0], 16'h0003);
    end
    for (int n = 0; n < 3; n++) begin
      cv[n] = 1'b1;
      settle();
      rdc(OP_RD_OUTPUT_SUMMARY_BIT_COND, n[1:0], 16'h0002);
      cc[n] = 1'b1;
      settle();
      rdc(OP_RD_OUTPUT_SUMMARY_BIT_COND, n[1:0], 16'h0003);
      cv[n] = 1'b0;
      settle();
      rdc(OP_RD_OUTPUT_SUMMARY_BIT_COND, n[1:0], 16'h0001);
      cv[n] = 1'b1;
      cc[n] = 1'b0;
      settle();
      rdc(OP_RD_OUTPUT_SUMMARY_BIT_COND, n[1:0], 16'h0002);
      rdc(OP_RD_OUTPUT_SUMMARY_BIT_EV, n[1:0], 16'h0003);
      rdc(OP_RD_INST_EV, 2'h0, 16'h0002 << n);
      rdc(OP_RD_QUESTIONABLE_SUMMARY_BIT_EV, 2'h0, 16'h2000);
      rdc(OP_RD_QUESTIONABLE_SUMMARY_BIT_EV, 2'h0, 16'h0000);
      cv[n] = 1'b0;
      settle();
    end
    // Fan fault, questionable mask and summary
    wr(OP_WR_QUESTIONABLE_SUMMARY_BIT_EN, 2'h0, 16'h2010);
    fan_fault = 1'b1;
    settle();
    fan_fault = 1'b0;
    settle();
    rdc(OP_RD_STB, 2'h0, 16'h0008);
    rdc(OP_RD_QUESTIONABLE_SUMMARY_BIT_EV, 2'h0, 16'h0010);
    rdc(OP_RD_STB, 2'h0, 16'h0000);
    wr(OP_CLS, 2'h0, 16'h0000);
    rdc(OP_RD_QUESTIONABLE_SUMMARY_BIT_EN, 2'h0, 16'h2010);
    fan_fault = 1'b1;
    settle();
    fan_fault = 1'b0;
    settle();
    wr(OP_CLS, 2'h0, 16'h0000);
    rdc(OP_RD_QUESTIONABLE_SUMMARY_BIT_EV, 2'h0, 16'h0000);
    wr(OP_WR_QUESTIONABLE_SUMMARY_BIT_EN, 2'h0, 16'h0000);
    rdc(OP_RD_QUESTIONABLE_SUMMARY_BIT_EN, 2'h0, 16'h0000);
    // Message available follows the output buffer
    @(negedge mclk);
    obuf_avail = 1'b1;
    rdc(OP_RD_STB, 2'h0, 16'h0010);
    obuf_avail = 1'b0;
    rdc(OP_RD_STB, 2'h0, 16'h0000);
    // Every standard event source but power cycle in turn
    wr(OP_WR_STD_EN, 2'h0, 16'h00BD);
    wr(OP_WR_SRE, 2'h0, 16'h0020);
    // Message bit stays up so the poll and reads must leave it alone
    obuf_avail = 1'b1;
    for (int i = 0; i < 7; i++) begin
      @(negedge mclk);
      ev = 7'h01 << i;
      @(negedge mclk);
      ev = 7'h00;
      chk({15'h0000, err_push}, {15'h0000, kind[i] != 4'h0});
      chk({12'h000, err_kind}, {12'h000, kind[i]});
      @(negedge mclk);
      chk({15'h0000, service_request}, 16'h0001);
      rdc(OP_SERIAL_POLL, 2'h0, 16'h0070);
      rdc(OP_RD_STB, 2'h0, 16'h0030);
      rdc(OP_RD_STD_EV, 2'h0, wgt[i]);
      rdc(OP_RD_STB, 2'h0, 16'h0010);
    end
    obuf_avail = 1'b0;
    // Power cycle with each power-on-clear setting
    for (int p = 0; p < 2; p++) begin
      wr(OP_WR_PSC, 2'h0, p[15:0]);
      rdc(OP_RD_PSC, 2'h0, p[15:0]);
      wr(OP_WR_STD_EN, 2'h0, 16'h00BD);
      wr(OP_WR_SRE, 2'h0, 16'h0038);
      @(negedge mclk);
      power_cycle = 1'b1;
      @(negedge mclk);
      power_cycle = 1'b0;
      rdc(OP_RD_STD_EN, 2'h0, (p == 1) ? 16'h0000 : 16'h00BD);
      rdc(OP_RD_SRE, 2'h0, (p == 1) ? 16'h0000 : 16'h0038);
      rdc(OP_RD_STD_EV, 2'h0, 16'h0080);
    end
    conclude();
  end
endmodule
`default_nettype wire
